// ===== hw/kms_scanner.sv
// module: top of the 8x8 keypad matrix scanner
// Overview of operation
// - selection lines are driven on select bits 00..07, sense lines read on sense bits 00..07.
// - the 64 matrix bits land in four consecutive 16-bit destination words, word 0 to word 3.
// - the whole 64-bit state is refreshed once every 24 controller cycles, then scanning repeats.
// - after all lines were selected once, the one-round flag on select bit 08 is high one cycle in 24.
// - each time execution resumes, the scan restarts at the first matrix position.
// scan timing: each selection line owns three steps of the work word,
// drive, refresh and sample, so a full pass over eight lines is 24 steps.
// a step is one controller cycle, given by step_stb while ce is high.
// the round result goes to the destination words in one go at step 23,
// so a reader never sees bytes of two different passes mixed together.
// limitation: no filtering here; contact bounce must be removed at the sense inputs.
`timescale 1ns/1ns
`default_nettype none

module kms_scanner
(
  input  wire logic                                       clk_sys,
  input  wire logic                                       nrst,
  input  wire logic                                       ce,
  input  wire logic                                       step_stb,
  input  wire logic                                       run,
  input  wire logic                                       work_clear,
  input  wire logic [7:0]                                 sense_word,
  output logic      [8:0]                                 select_word,
  output logic      [kms_pkg::WORDS-1:0][kms_pkg::WORD_W-1:0] dest_words,
  output logic      [4:0]                                 work_word,
  output logic                                            instruction_error_flag
);

  // ****************************************************************
  // state and decode
  // ****************************************************************
  kms_pkg::kms_state_t s_q;
  kms_pkg::kms_state_t s_d;
  logic [2:0]          line;
  logic [1:0]          phase;
  logic                running;
  logic                step;
  logic                resume;

  kms_step_decode u_dec
  (
    .pos   (s_q.pos),
    .line  (line),
    .phase (phase)
  );

  // a step only counts once the scanner has already been running
  assign running = run && s_q.run_prev;
  assign step    = step_stb && running;
  assign resume  = run && !s_q.run_prev;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    s_d          = s_q;
    s_d.run_prev = run;
    s_d.err      = 1'b0;                                   // never raised
    if (work_clear)
    begin
      // line and flag follow the cleared word so drive and position agree
      s_d.pos                 = kms_pkg::POS_RESET;
      s_d.sel_word.sel        = kms_pkg::SEL_FIRST;
      s_d.sel_word.round_flag = 1'b0;
    end
    else if (resume)
    begin
      // old position is discarded whatever it was
      s_d.pos                 = kms_pkg::POS_RESET;
      s_d.sel_word.sel        = kms_pkg::SEL_FIRST;
      s_d.sel_word.round_flag = 1'b0;
    end
    else if (step)
    begin
      s_d.sel_word.round_flag = 1'b0;
      if (phase == kms_pkg::SAMPLE_PH)
      begin
        // line was driven two steps ago, so pins are settled
        s_d.shadow[line*kms_pkg::SENSE_W +: kms_pkg::SENSE_W] = sense_word;
        s_d.sel_word.sel = 8'(kms_pkg::SEL_FIRST << 3'(line + 3'h1));
      end
      if (s_q.pos == kms_pkg::LAST_POS)
      begin
        s_d.pos                 = kms_pkg::POS_RESET;
        s_d.sel_word.round_flag = 1'b1;
        // copy whole round at once so readers never see a mixed scan
        s_d.dest = s_d.shadow;
      end
      else
      begin
        s_d.pos = 5'(s_q.pos + 5'h01);
      end
    end
  end

  // ****************************************************************
  // state register, frozen while ce is low
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      s_q <= '0;
    end
    else if (ce)
    begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state register
  assign select_word            = s_q.sel_word;
  assign dest_words             = s_q.dest;
  assign work_word              = s_q.pos;
  assign instruction_error_flag = s_q.err;

  // ****************************************************************
  // checks
  // ****************************************************************
  a_sel_one_hot: assert property (@(posedge clk_sys) disable iff (!nrst)
    $onehot0(s_q.sel_word.sel))
    else $error("more than one selection line active");

  a_pos_in_range: assert property (@(posedge clk_sys) disable iff (!nrst)
    s_q.pos <= kms_pkg::LAST_POS)
    else $error("scan position beyond last step");

  a_round_wraps: assert property (@(posedge clk_sys) disable iff (!nrst)
    ce && step && !work_clear && s_q.pos == kms_pkg::LAST_POS |=> s_q.pos == 5'h00)
    else $error("scan did not restart after last step");

  a_flag_after_round: assert property (@(posedge clk_sys) disable iff (!nrst)
    ce && step && !work_clear && s_q.pos == kms_pkg::LAST_POS |=> s_q.sel_word.round_flag)
    else $error("one-round flag missing after last line");

  a_flag_one_step: assert property (@(posedge clk_sys) disable iff (!nrst)
    ce && step && s_q.sel_word.round_flag |=> !s_q.sel_word.round_flag)
    else $error("one-round flag held past one cycle");

  a_resume_restart: assert property (@(posedge clk_sys) disable iff (!nrst)
    ce && run && !s_q.run_prev |=> s_q.pos == 5'h00 && s_q.sel_word.sel == 8'h01)
    else $error("resume did not restart at first position");

  a_last_line_lands: assert property (@(posedge clk_sys) disable iff (!nrst)
    ce && step && !work_clear && s_q.pos == kms_pkg::LAST_POS
    |=> s_q.dest[3][15:8] == $past(sense_word))
    else $error("last line not stored in top byte of word 3");

  a_dest_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
    !(ce && step && !work_clear && s_q.pos == kms_pkg::LAST_POS) |=> $stable(s_q.dest))
    else $error("destination words changed mid-round");

  a_sel_steady: assert property (@(posedge clk_sys) disable iff (!nrst)
    ce && step && !work_clear && phase != 2'h2 |=> $stable(s_q.sel_word.sel))
    else $error("selection changed before its line was sensed");

  a_sense_phase_only: assert property (@(posedge clk_sys) disable iff (!nrst)
    ce && step && !work_clear && phase != kms_pkg::SAMPLE_PH |=> $stable(s_q.shadow))
    else $error("sense bits stored outside the sample step");

  // drive must name the line that the work word points at, or no line at all
  a_sel_follows_pos: assert property (@(posedge clk_sys) disable iff (!nrst)
    s_q.sel_word.sel == kms_pkg::SEL_RESET
    || s_q.sel_word.sel == 8'(kms_pkg::SEL_FIRST << line))
    else $error("selection line does not match scan position");

  a_wrap_first_line: assert property (@(posedge clk_sys) disable iff (!nrst)
    ce && step && !work_clear && s_q.pos == kms_pkg::LAST_POS
    |=> s_q.sel_word.sel == kms_pkg::SEL_FIRST)
    else $error("new round did not start on the first line");

  a_pos_advances: assert property (@(posedge clk_sys) disable iff (!nrst)
    ce && step && !work_clear && s_q.pos != kms_pkg::LAST_POS
    |=> s_q.pos == 5'($past(s_q.pos) + 5'h01))
    else $error("scan position did not advance by one");

  // the flag may only come from the wrap of the last step
  a_flag_rise_wrap: assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(s_q.sel_word.round_flag)
    |-> $past(s_q.pos) == kms_pkg::LAST_POS && s_q.pos == kms_pkg::POS_RESET)
    else $error("one-round flag raised away from round end");

  a_round_copy: assert property (@(posedge clk_sys) disable iff (!nrst)
    ce && step && !work_clear && s_q.pos == kms_pkg::LAST_POS
    |=> s_q.dest[2:0] == $past(s_q.shadow[47:0]))
    else $error("words 0 to 2 not copied from the finished round");

  // ****************************************************************
  // checks on freeze, stop and clear
  // ****************************************************************
  // a frozen or stopped scanner must not lose its place or its results
  a_freeze_all: assert property (@(posedge clk_sys) disable iff (!nrst)
    !ce |=> $stable(s_q))
    else $error("state changed while clock enable was low");

  a_stopped_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
    ce && !run && !work_clear
    |=> $stable(s_q.pos) && $stable(s_q.sel_word) && $stable(s_q.dest))
    else $error("scan moved while not executing");

  a_resume_flag_low: assert property (@(posedge clk_sys) disable iff (!nrst)
    ce && resume |=> !s_q.sel_word.round_flag)
    else $error("one-round flag high after resume");

  // clearing restarts drive too, otherwise line 0 would read another line
  a_clear_restart: assert property (@(posedge clk_sys) disable iff (!nrst)
    ce && work_clear |=> s_q.pos == kms_pkg::POS_RESET
    && s_q.sel_word.sel == kms_pkg::SEL_FIRST && !s_q.sel_word.round_flag)
    else $error("clear did not restart the scan");

endmodule

`default_nettype wire

// ===== hw/kms_pkg.sv
// package: constants and carrier types of the keypad matrix scanner
package kms_pkg;

  // ****************************************************************
  // geometry of the matrix and of the destination words
  // ****************************************************************
  localparam int unsigned LINES      = 8;   // selection lines, bits 00..07
  localparam int unsigned SENSE_W    = 8;   // sense lines, bits 00..07
  localparam int unsigned WORDS      = 4;   // destination words
  localparam int unsigned WORD_W     = 16;  // bits per destination word
  localparam int unsigned FLAG_BIT   = 8;   // one-round flag in select word
  localparam int unsigned POS_W      = 5;

  // ****************************************************************
  // timing in controller cycles
  // ****************************************************************
  localparam int unsigned PHASES     = 3;   // drive, refresh, sample
  localparam int unsigned ROUND_STEPS = LINES * PHASES;  // 24 cycles
  localparam logic [4:0]  LAST_POS   = 5'(ROUND_STEPS - 1);
  localparam logic [4:0]  POS_RESET  = 5'h00;
  localparam logic [1:0]  SAMPLE_PH  = 2'h2;
  localparam logic [2:0]  LAST_LINE  = 3'h7;
  localparam logic [7:0]  SEL_FIRST  = 8'h01;
  localparam logic [7:0]  SEL_RESET  = 8'h00;

  // select output word: flag above the eight selection lines
  typedef struct packed {
    logic       round_flag;
    logic [7:0] sel;
  } kms_sel_t;

  // whole state of the scanner
  typedef struct packed {
    logic [4:0]                         pos;       // work word
    logic                               run_prev;
    kms_sel_t                           sel_word;
    logic [LINES*SENSE_W-1:0]           shadow;
    logic [WORDS-1:0][WORD_W-1:0]       dest;
    logic                               err;
  } kms_state_t;

endpackage

// ===== hw/kms_step_decode.sv
// module: splits the scan position into line and phase
`timescale 1ns/1ns
`default_nettype none

module kms_step_decode
(
  input  wire logic [4:0] pos,
  output logic      [2:0] line,
  output logic      [1:0] phase
);

  // ****************************************************************
  // three controller cycles per selection line
  // ****************************************************************
  assign line  = 3'(pos / 5'h03);
  assign phase = 2'(pos % 5'h03);

endmodule

`default_nettype wire

// ===== hw/kms_scanner_note_unused.sv
// spare design file: holds no logic of the scanner
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// ===== tb/kms_key_matrix.sv
// partner model: passive 8x8 key matrix behind refreshed select pins
`timescale 1ns/1ns
`default_nettype none

module kms_key_matrix
(
  input  wire logic        clk_sys,
  input  wire logic [7:0]  select_pins,
  input  wire logic [63:0] keys,
  output logic      [7:0]  sense_pins
);
  logic [7:0] pins_q;

  // pins refreshed once a cycle, so sensing lags the select word
  always_ff @(posedge clk_sys)
  begin
    pins_q <= select_pins;
  end

  // closed keys join a driven line to its column; pull-downs elsewhere
  always_comb
  begin
    sense_pins = 8'h00;
    for (int l = 0; l < 8; l++)
    begin
      if (pins_q[l])
      begin
        sense_pins = sense_pins | keys[l*8 +: 8];
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb/test_kms_scanner.sv
// testbench: scan rounds, resume, freeze and clear of the matrix scanner
`timescale 1ns/1ns
`default_nettype none

module test_kms_scanner;
  logic                                           clk_sys;
  logic                                           nrst;
  logic                                           ce;
  logic                                           step_stb;
  logic                                           run;
  logic                                           work_clear;
  logic [7:0]                                     sense_word;
  logic [8:0]                                     select_word;
  logic [kms_pkg::WORDS-1:0][kms_pkg::WORD_W-1:0] dest_words;
  logic [4:0]                                     work_word;
  logic                                           instruction_error_flag;
  logic [63:0]                                    keys;
  int                                             n_mismatch;
  int                                             samples_checked;
  int                                             exp_pos;

  kms_scanner u_kms_scanner (.clk_sys(clk_sys), .nrst(nrst), .ce(ce), .step_stb(step_stb),
    .run(run), .work_clear(work_clear), .sense_word(sense_word), .select_word(select_word),
    .dest_words(dest_words), .work_word(work_word),
    .instruction_error_flag(instruction_error_flag));
  kms_key_matrix u_kms_key_matrix (.clk_sys(clk_sys), .select_pins(select_word[7:0]),
    .keys(keys), .sense_pins(sense_word));

  // 10 MHz controller clock
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // ****************************************
  // compare, drive and closing tasks
  // ****************************************
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
  begin
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  end
  endtask

  // one step; the next round must start on line 0 again, not on no line
  task automatic step_chk();
  begin
    @(posedge clk_sys);
    step_stb <= 1'b1;
    @(posedge clk_sys);
    step_stb <= 1'b0;
    @(negedge clk_sys);
    exp_pos = (exp_pos + 1) % 24;
    chk("work_word", 64'(exp_pos), 64'(work_word));
    chk("select_word", {55'h0, exp_pos == 0, 8'h01 << (exp_pos / 3)}, 64'(select_word));
  end
  endtask

  // run low for one taken edge, then high again
  task automatic resume();
  begin
    @(posedge clk_sys);
    run <= 1'b0;
    @(posedge clk_sys);
    run <= 1'b1;
    @(posedge clk_sys);
    @(negedge clk_sys);
    exp_pos = 0;
    chk("work_word", 64'h0, 64'(work_word));
    chk("select_word", 64'h001, 64'(select_word));
  end
  endtask

  task automatic close_out();
  begin
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  end
  endtask

  // watchdog: whole sequence needs well under 400 cycles
  initial
  begin
    repeat (3000) @(posedge clk_sys);
    n_mismatch++;
    close_out();
  end

  // main sequence
  initial
  begin
    nrst = 1'b0;
    ce = 1'b1;
    step_stb = 1'b0;
    run = 1'b0;
    work_clear = 1'b0;
    keys = 64'h8040_2010_0804_0201;
    n_mismatch = 0;
    samples_checked = 0;
    exp_pos = 0;
    repeat (10) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    work_clear <= 1'b1;
    @(posedge clk_sys);
    work_clear <= 1'b0;
    resume();
    repeat (24) step_chk();
    chk("dest_words", keys, 64'(dest_words));
    @(posedge clk_sys);
    keys <= 64'hA5C3_0F00_FF12_3481;
    repeat (24) step_chk();
    chk("dest_words", keys, 64'(dest_words));
    repeat (7) step_chk();
    resume();
    // ce low must freeze the scan position
    @(posedge clk_sys);
    ce <= 1'b0;
    step_stb <= 1'b1;
    @(posedge clk_sys);
    step_stb <= 1'b0;
    ce <= 1'b1;
    @(negedge clk_sys);
    chk("work_word", 64'h0, 64'(work_word));
    repeat (4) step_chk();
    // a step while run is low must be ignored
    @(posedge clk_sys);
    run <= 1'b0;
    @(posedge clk_sys);
    step_stb <= 1'b1;
    @(posedge clk_sys);
    step_stb <= 1'b0;
    @(negedge clk_sys);
    chk("work_word", 64'(exp_pos), 64'(work_word));
    @(posedge clk_sys);
    work_clear <= 1'b1;
    @(posedge clk_sys);
    work_clear <= 1'b0;
    @(negedge clk_sys);
    chk("work_word", 64'h0, 64'(work_word));
    chk("select_word", 64'h001, 64'(select_word));
    chk("error_flag", 64'h0, 64'(instruction_error_flag));
    close_out();
  end
endmodule
`default_nettype wire
